// ===== testbench/tb.sv
// Bench: host end drives one device; a second host checks refusals.
// Assumes the package and interface files are compiled first.
`timescale 1ns/1ps

module tb;
    logic clk_sys, srst, cmd_valid, cmd_valid2, hold_disable;
    logic [31:0] cmd_word;
    logic [63:0] cmd_word2;
    logic done, refused, h_loaded, done2, refused2, h_busy, h_ready;
    logic [7:0] out_enable;
    logic [23:0] out_source;
    logic [31:0] shift_word;
    logic d_loaded, early_update, shift_in_update;
    logic [7:0] ee;
    logic [23:0] es;
    logic [31:0] ew;
    int fail_count, checked;
    // Routing table: sources, enables, hold, refusal expected
    logic [23:0] ts [5] = '{24'hFAC21A, 24'h23EB1A, 24'h23EB1A, 24'hFAC222, 24'h208208};
    logic [7:0] te [5] = '{8'hCF, 8'hFF, 8'hFF, 8'hCF, 8'h00};
    logic hd [5] = '{1'h0, 1'h1, 1'h0, 1'h0, 1'h0};
    logic tr [5] = '{1'h0, 1'h0, 1'h0, 1'h1, 1'h0};

    xp_link_if link ();
    xp_link_if link2 ();
    // No device on the second link; its data loops back unread
    assign link2.sdo = link2.sdata;

    xp_host_end #(.N_DEV(1), .GROUP(2)) i_xp_host_end (.clk_sys(clk_sys), .srst(srst), .link(link),
        .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(h_ready), .hold_disable(hold_disable),
        .busy(h_busy), .done(done), .refused(refused), .loaded(h_loaded));
    xp_dev_end i_xp_dev_end (.clk_sys(clk_sys), .srst(srst), .link(link), .out_enable(out_enable),
        .out_source(out_source), .shift_word(shift_word), .bits_seen(), .loaded(d_loaded),
        .early_update(early_update), .shift_in_update(shift_in_update));
    xp_host_end #(.N_DEV(2), .WIRED(1), .GROUP(3)) i_xp_host_end_2 (.clk_sys(clk_sys), .srst(srst),
        .link(link2), .cmd_valid(cmd_valid2), .cmd_word(cmd_word2), .cmd_ready(), .hold_disable(hold_disable),
        .busy(), .done(done2), .refused(refused2), .loaded());
    xp_link_sva i_xp_link_sva (.clk_sys(clk_sys), .srst(srst), .ce_n(link.ce_n), .update_n(link.update_n),
        .sclk(link.sclk), .sdata(link.sdata), .reset_n(link.reset_n),
        .interface_mode_select(link.interface_mode_select), .sdo(link.sdo));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] wd(input logic [23:0] s, input logic [7:0] e);
        logic [31:0] w;
        for (int k = 0; k < 8; k++) begin
            w[4*k +: 4] = {s[3*k], s[3*k+1], s[3*k+2], e[k]};
        end
        return w;
    endfunction : wd

    function automatic logic [23:0] msk(input logic [23:0] s, input logic [7:0] e);
        logic [23:0] m;
        for (int k = 0; k < 8; k++) begin
            m[3*k +: 3] = e[k] ? s[3*k +: 3] : 3'h0;
        end
        return m;
    endfunction : msk

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // One load request; waits for done or refusal under a bound
    task automatic ld(input logic sel, input logic [63:0] w, input logic hold, input logic ref_exp);
        int n;
        @(posedge clk_sys);
        hold_disable <= hold;
        cmd_word <= w[31:0];
        cmd_word2 <= w;
        cmd_valid <= !sel;
        cmd_valid2 <= sel;
        @(posedge clk_sys);
        cmd_valid <= 1'h0;
        cmd_valid2 <= 1'h0;
        #1;
        if (!sel) begin
            chk(h_busy, !ref_exp);
        end
        for (n = 0; n < 2000; n++) begin
            #1;
            if ((sel ? (done2 | refused2) : (done | refused)) === 1'h1) break;
            @(posedge clk_sys);
        end
        if (n == 2000) begin
            fail_count++;
            finish_test();
        end
        chk(sel ? refused2 : refused, ref_exp);
        if (!sel) begin
            chk({h_busy, h_ready}, 32'h1);
        end
    endtask : ld

    // ****************************************************************
    // Stimulus
    // ****************************************************************
    initial begin
        clk_sys = 1'h0;
        forever #5 clk_sys = ~clk_sys;
    end

    initial begin
        srst = 1'h1;
        cmd_valid = 1'h0;
        cmd_valid2 = 1'h0;
        cmd_word = '0;
        cmd_word2 = '0;
        hold_disable = 1'h0;
        fail_count = 0;
        checked = 0;
        repeat (20) @(posedge clk_sys);
        srst <= 1'h0;
        repeat (6) @(posedge clk_sys);
        #1;
        chk(out_enable, 32'h0);
        chk(link.reset_n, 32'h0);
        chk({d_loaded, early_update, h_loaded}, 32'h0);
        for (int i = 0; i < 5; i++) begin
            ld(1'h0, {32'h0, wd(ts[i], te[i])}, hd[i], tr[i]);
            if (!tr[i]) begin
                ee = hd[i] ? 8'h00 : te[i];
                es = msk(ts[i], te[i]);
                ew = wd(ts[i], te[i]);
            end
            repeat (8) @(posedge clk_sys);
            #1;
            chk(out_enable, ee);
            chk(out_source, es);
            chk(shift_word, ew);
            chk({early_update, shift_in_update, d_loaded}, 32'h1);
        end
        // Outputs drop and come back with the pin; programming is kept meanwhile
        ld(1'h0, {32'h0, wd(ts[1], te[1])}, 1'h0, 1'h0);
        repeat (8) @(posedge clk_sys);
        hold_disable <= 1'h1;
        repeat (8) @(posedge clk_sys);
        #1;
        chk(out_enable, 32'h0);
        chk(shift_word, wd(ts[1], te[1]));
        chk(out_source, msk(ts[1], te[1]));
        chk(h_loaded, 32'h1);
        @(posedge clk_sys);
        hold_disable <= 1'h0;
        repeat (8) @(posedge clk_sys);
        #1;
        chk(out_enable, te[1]);
        ld(1'h1, {wd(24'h011163, 8'h38), wd(24'h02C688, 8'h07)}, 1'h0, 1'h0);
        ld(1'h1, {wd(24'h011163, 8'h3F), wd(24'h02C688, 8'h07)}, 1'h0, 1'h1);
        ld(1'h1, {wd(24'h011163, 8'h38), wd(24'h02C788, 8'h07)}, 1'h0, 1'h1);
        finish_test();
    end
endmodule : tb

// ===== testbench/xp_link_sva.sv
// Checker of the serial link pins between the host end and one device.
// Assumes one device on the link, 8-cycle half periods and update pulse.
`timescale 1ns/1ps

module xp_link_sva (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic ce_n, // Chip select
    input wire logic update_n, // Update strobe
    input wire logic sclk, // Serial clock
    input wire logic sdata, // Serial data
    input wire logic reset_n, // Output disable
    input wire logic interface_mode_select, // Serial or parallel
    input wire logic sdo // Serial data out of the device
);
    // ****************************************************************
    // Falls of the serial clock inside the current frame
    // ****************************************************************
    logic sclk_r;
    logic first_r;
    logic [6:0] cnt_r;
    logic [6:0] cnt_nxt;

    always_comb begin
        cnt_nxt = cnt_r;
        if (ce_n) begin
            cnt_nxt = 7'h00;
        end else if (sclk_r && !sclk) begin
            cnt_nxt = cnt_r + 7'h01;
        end
    end

    // A full word seen once makes the shift register safe to apply
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sclk_r <= 1'h1;
            cnt_r <= 7'h00;
            first_r <= 1'h0;
        end else begin
            sclk_r <= sclk;
            cnt_r <= cnt_nxt;
            first_r <= first_r | (cnt_r == 7'h20);
        end
    end

    // ****************************************************************
    // Properties
    // ****************************************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (srst);

    sequence s_upd_pulse;
        (!update_n) [*8] ##1 update_n;
    endsequence
    sequence s_first_half;
        sclk [*8] ##1 !sclk;
    endsequence

    property p_serial; interface_mode_select == 1'h0; endproperty
    property p_no_early; !first_r |-> !(!ce_n && !update_n); endproperty
    property p_full_before_upd; $fell(update_n) |-> cnt_r == 7'h20; endproperty
    property p_frame_len; $rose(ce_n) |-> cnt_r == 7'h20; endproperty
    property p_upd_len; $fell(update_n) |-> s_upd_pulse; endproperty
    property p_idle; ce_n |-> sclk && update_n; endproperty
    property p_data_steady; $fell(sclk) |-> $stable(sdata); endproperty
    property p_start; $fell(ce_n) |-> s_first_half; endproperty
    property p_off_early; !first_r |-> !reset_n; endproperty
    // The device shifts only inside a frame, so its chain output moves only then
    property p_sdo_frame; $changed(sdo) |-> !ce_n; endproperty

    a_serial: assert property (p_serial) else $error("link left serial mode");
    a_no_early: assert property (p_no_early) else $error("update before first full load");
    a_full_before_upd: assert property (p_full_before_upd) else $error("update before word complete");
    a_frame_len: assert property (p_frame_len) else $error("frame length wrong");
    a_upd_len: assert property (p_upd_len) else $error("update pulse length wrong");
    a_idle: assert property (p_idle) else $error("clock or update active outside frame");
    a_data_steady: assert property (p_data_steady) else $error("data moved at clock fall");
    a_start: assert property (p_start) else $error("first clock fall misplaced");
    a_off_early: assert property (p_off_early) else $error("outputs enabled before first load");
    a_sdo_frame: assert property (p_sdo_frame) else $error("chain output moved outside a frame");
endmodule : xp_link_sva

// ===== verilog/xp_dev_end.sv
// Device end: serial control logic of one 8x8 crosspoint switch.
// Assumes every link pin is asynchronous to clk_sys; all are synchronised.
// The serial clock must stay well below clk_sys/4 so each edge is seen.
`timescale 1ns/1ps
`include "xp_regs.svh"

// Notes on behaviour
// - Reset pin low disables every output.
// - Reset pin leaves shift and matrix intact.
// - Serial pass rewrites every output field.
// - Shift contents undefined until host loads.
// - Host avoids chip-select and update together early.
// - Host shifts full word before update.
// - Reset high resumes normal programming.
// - Host keeps one enabled driver per node.
// - Host programs paired channels consistently.
// - Host programs triple channels consistently.
// - Thirty-two bits per chained device.
// - Field is three source bits, enable.
// - Update latches transparent while strobe low and chip select active.
// - Host sends highest output field first.
module xp_dev_end import xp_pkg::*; (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    xp_link_if.dev link, // Pins from the host
    output logic [`XP_NUM_OUT-1:0] out_enable, // Per-output drive enable
    output logic [`XP_NUM_OUT*`XP_SRC_BITS-1:0] out_source, // Per-output source select
    output logic [`XP_WORD_BITS-1:0] shift_word, // Shift register contents
    output logic [5:0] bits_seen, // Bits shifted in this frame
    output logic loaded, // A full word has been shifted
    output logic early_update, // Matrix took data before a full load
    output logic shift_in_update // Shifting happened while latches open
);

    localparam logic [5:0] FULL = 6'(`XP_WORD_BITS);

    xp_dev_s q;
    xp_dev_s n;

    logic fall;
    logic ce_act;
    logic upd_open;
    logic rst_act;

    // ****************************************************************
    // Pin decode
    // ****************************************************************
    always_comb begin
        fall = q.sclk_prev & ~q.s2[SY_SCLK];
        ce_act = ~q.s2[SY_CE_N];
        // Parallel mode is not served here; it blocks shifting but not latching
        upd_open = ce_act & ~q.s2[SY_UPD_N];
        rst_act = ~q.s2[SY_RST_N];
    end

    // ****************************************************************
    // Shift register, update latches and output drive
    // ****************************************************************
    always_comb begin
        n = q;
        n.s1 = {link.reset_n, link.interface_mode_select, link.ce_n, link.update_n, link.sclk, link.sdata};
        n.s2 = q.s1;
        n.sclk_prev = q.s2[SY_SCLK];

        // A new frame starts counting when chip select goes away
        if (!ce_act) begin
            n.bits_seen = '0;
        end

        // Reset pin does not gate shifting or latching
        if (fall && ce_act && !q.s2[SY_MODE]) begin
            n.shift = {q.shift[`XP_WORD_BITS-2:0], q.s2[SY_SDATA]};
            if (q.bits_seen != FULL) begin
                n.bits_seen = q.bits_seen + 6'h01;
            end
            if (q.bits_seen == FULL - 6'h01) begin
                n.loaded = 1'b1;
            end
            if (upd_open) begin
                n.shift_in_update = 1'b1;
            end
        end

        // Latches follow the shift register while the strobe is low and chip select is active
        if (upd_open) begin
            n.matrix = n.shift;
            if (!q.loaded) begin
                n.early_update = 1'b1;
            end
        end

        for (int k = 0; k < `XP_NUM_OUT; k++) begin
            // Outputs with a clear enable bit report source zero so nothing stale is routed
            n.en[k] = xp_en(n.matrix, k) & ~rst_act;
            if (xp_en(n.matrix, k)) begin
                n.src[k*`XP_SRC_BITS +: `XP_SRC_BITS] = xp_src(n.matrix, k);
            end else begin
                n.src[k*`XP_SRC_BITS +: `XP_SRC_BITS] = '0;
            end
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            // Power-up contents are modelled as zero; software must not rely on it
            q <= XP_DEV_RST;
        end else begin
            q <= n;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign link.sdo = q.shift[`XP_WORD_BITS-1];
    assign out_enable = q.en;
    assign out_source = q.src;
    assign shift_word = q.shift;
    assign bits_seen = q.bits_seen;
    assign loaded = q.loaded;
    assign early_update = q.early_update;
    assign shift_in_update = q.shift_in_update;

endmodule : xp_dev_end

// ===== verilog/xp_host_end.sv
// Host end: loads full routing words into a chain of crosspoint devices.
// Assumes cmd_* and hold_disable come from logic on clk_sys.
`timescale 1ns/1ps
`include "xp_regs.svh"

module xp_host_end import xp_pkg::*; #(
    parameter int N_DEV = 1,
    parameter int WIRED = 0,
    parameter int GROUP = 1,
    parameter int HALF_CYC = `XP_SCLK_HALF_CYC,
    parameter int UPD_CYC = `XP_UPD_LOW_CYC
) (
    input wire logic clk_sys, // System clock
    input wire logic srst, // Synchronous reset
    xp_link_if.host link, // Pins to the device chain
    input wire logic cmd_valid, // Request to load a word
    input wire logic [`XP_WORD_BITS*N_DEV-1:0] cmd_word, // Last device in top bits
    output logic cmd_ready, // Idle, request taken
    input wire logic hold_disable, // Keep all outputs disabled
    output logic busy, // Transfer in progress
    output logic done, // Transfer finished
    output logic refused, // Request broke a routing constraint
    output logic loaded // At least one full load done
);

    localparam int TB = `XP_WORD_BITS * N_DEV;

    // ****************************************************************
    // Parameter checks
    // ****************************************************************
    if (N_DEV < 1 || N_DEV > 1000 || GROUP < 1 || GROUP > 3 || HALF_CYC < 1 || HALF_CYC > 255 ||
        UPD_CYC < 1 || UPD_CYC > 255) begin : g_bad
        $error("xp_host_end: unsupported parameter value");
    end

    typedef struct packed {
        xp_host_e st;
        logic [7:0] tmr;
        logic [15:0] bits;
        logic [TB-1:0] word;
        logic sclk;
        logic sdata;
        logic ce_n;
        logic upd_n;
        logic rst_n;
        logic loaded;
        logic done;
        logic refused;
    } xp_host_s;

    localparam xp_host_s HOST_RST = '{st: HS_IDLE, sclk: 1'b1, ce_n: 1'b1, upd_n: 1'b1, default: '0};
    localparam logic [7:0] HALF_M1 = 8'(HALF_CYC - 1);
    localparam logic [7:0] UPD_M1 = 8'(UPD_CYC - 1);
    localparam logic [15:0] TB_W = 16'(TB);

    xp_host_s q;
    xp_host_s n;

    // ****************************************************************
    // Routing constraint check
    // ****************************************************************
    function automatic logic word_ok(input logic [TB-1:0] w);
        logic ok;
        int cnt;
        xp_word_t dw;
        logic [`XP_SRC_BITS-1:0] b;
        ok = 1'b1;
        cnt = 0;
        dw = '0;
        b = '0;
        for (int k = 0; k < `XP_NUM_OUT; k++) begin
            cnt = 0;
            for (int d = 0; d < N_DEV; d++) begin
                dw = w[d*`XP_WORD_BITS +: `XP_WORD_BITS];
                cnt = cnt + int'(xp_en(dw, k));
            end
            if (WIRED != 0 && cnt > 1) begin
                ok = 1'b0;
            end
        end
        for (int d = 0; d < N_DEV; d++) begin
            dw = w[d*`XP_WORD_BITS +: `XP_WORD_BITS];
            for (int g = 0; g + GROUP <= `XP_NUM_OUT; g += GROUP) begin
                b = xp_src(dw, g);
                if (GROUP > 1 && ((int'(b) % GROUP) != 0 || int'(b) + GROUP > `XP_NUM_OUT)) begin
                    ok = 1'b0;
                end
                for (int j = 1; j < GROUP; j++) begin
                    if (xp_en(dw, g + j) != xp_en(dw, g) || int'(xp_src(dw, g + j)) != int'(b) + j) begin
                        ok = 1'b0;
                    end
                end
            end
        end
        return ok;
    endfunction : word_ok

    // ****************************************************************
    // Transfer sequencer
    // ****************************************************************
    always_comb begin
        n = q;
        n.done = 1'b0;
        n.refused = 1'b0;
        case (q.st)
            HS_IDLE: begin
                if (cmd_valid) begin
                    if (word_ok(cmd_word)) begin
                        n.word = cmd_word;
                        n.ce_n = 1'b0;
                        n.sclk = 1'b1;
                        n.sdata = cmd_word[TB-1];
                        n.bits = '0;
                        n.tmr = '0;
                        n.st = HS_SHIFT;
                    end else begin
                        n.refused = 1'b1;
                    end
                end
            end
            HS_SHIFT: begin
                if (q.tmr == HALF_M1) begin
                    n.tmr = '0;
                    if (q.sclk) begin
                        n.sclk = 1'b0;
                        n.bits = q.bits + 16'h0001;
                    end else if (q.bits == TB_W) begin
                        // Update only once the whole chain holds the new word
                        n.sclk = 1'b1;
                        n.upd_n = 1'b0;
                        n.st = HS_UPD;
                    end else begin
                        n.sclk = 1'b1;
                        n.word = {q.word[TB-2:0], 1'b0};
                        n.sdata = q.word[TB-2];
                    end
                end else begin
                    n.tmr = q.tmr + 8'h01;
                end
            end
            HS_UPD: begin
                if (q.tmr == UPD_M1) begin
                    n.tmr = '0;
                    n.upd_n = 1'b1;
                    n.st = HS_ENDS;
                end else begin
                    n.tmr = q.tmr + 8'h01;
                end
            end
            HS_ENDS: begin
                if (q.tmr == HALF_M1) begin
                    n.tmr = '0;
                    n.ce_n = 1'b1;
                    n.done = 1'b1;
                    n.loaded = 1'b1;
                    n.st = HS_IDLE;
                end else begin
                    n.tmr = q.tmr + 8'h01;
                end
            end
            default: begin
                n = HOST_RST;
            end
        endcase
        // Outputs stay disabled until the first full load has reached the matrix
        n.rst_n = n.loaded & ~hold_disable;
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            q <= HOST_RST;
        end else begin
            q <= n;
        end
    end

    assign link.ce_n = q.ce_n;
    assign link.update_n = q.upd_n;
    assign link.sclk = q.sclk;
    assign link.sdata = q.sdata;
    assign link.reset_n = q.rst_n;
    assign link.interface_mode_select = 1'b0;
    assign cmd_ready = (q.st == HS_IDLE);
    assign busy = (q.st != HS_IDLE);
    assign done = q.done;
    assign refused = q.refused;
    assign loaded = q.loaded;

endmodule : xp_host_end

// ===== verilog/xp_link_if.sv
// Pins between the programming host and one crosspoint device.
// Assumes the bench joins chained devices by linking sdo to the next sdata.
`timescale 1ns/1ps

interface xp_link_if;
    logic ce_n;
    logic update_n;
    logic sclk;
    logic sdata;
    logic sdo;
    logic reset_n;
    logic interface_mode_select;

    modport host (
        output ce_n,
        output update_n,
        output sclk,
        output sdata,
        output reset_n,
        output interface_mode_select,
        input sdo
    );

    modport dev (
        input ce_n,
        input update_n,
        input sclk,
        input sdata,
        input reset_n,
        input interface_mode_select,
        output sdo
    );
endinterface : xp_link_if

// ===== verilog/xp_pkg.sv
// Types shared by both ends of the crosspoint control link.
// Assumes xp_regs.svh is on the include path.
`include "xp_regs.svh"

package xp_pkg;

    // ****************************************************************
    // Synchroniser bit order on the device end
    // ****************************************************************
    localparam int SY_SDATA = 0;
    localparam int SY_SCLK = 1;
    localparam int SY_UPD_N = 2;
    localparam int SY_CE_N = 3;
    localparam int SY_MODE = 4;
    localparam int SY_RST_N = 5;
    localparam logic [5:0] SY_IDLE = 6'h0E;

    typedef logic [`XP_WORD_BITS-1:0] xp_word_t;

    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_SHIFT = 4'h2,
        HS_UPD = 4'h4,
        HS_ENDS = 4'h8
    } xp_host_e;

    typedef struct packed {
        logic [5:0] s1;
        logic [5:0] s2;
        logic sclk_prev;
        xp_word_t shift;
        xp_word_t matrix;
        logic [`XP_NUM_OUT-1:0] en;
        logic [`XP_NUM_OUT*`XP_SRC_BITS-1:0] src;
        logic [5:0] bits_seen;
        logic loaded;
        logic early_update;
        logic shift_in_update;
    } xp_dev_s;

    localparam xp_dev_s XP_DEV_RST = '{s1: SY_IDLE, s2: SY_IDLE, sclk_prev: 1'b1, default: '0};

    // Source select of output k inside one 32-bit word
    function automatic logic [`XP_SRC_BITS-1:0] xp_src(input xp_word_t w, input int k);
        logic [`XP_SRC_BITS-1:0] s;
        s = '0;
        for (int j = 0; j < `XP_SRC_BITS; j++) begin
            s[j] = w[k*`XP_FIELD_BITS + `XP_SRC0_POS - j];
        end
        return s;
    endfunction : xp_src

    function automatic logic xp_en(input xp_word_t w, input int k);
        return w[k*`XP_FIELD_BITS + `XP_EN_POS];
    endfunction : xp_en

endpackage : xp_pkg

// ===== verilog/xp_regs.svh
// Constants of the crosspoint serial control link: word layout and timing.
// Assumes a 100 MHz system clock on both ends; included by its bare name.
`ifndef XP_REGS_SVH
`define XP_REGS_SVH

// ****************************************************************
// Word and field layout
// ****************************************************************
`define XP_WORD_BITS 32
`define XP_NUM_OUT 8
`define XP_FIELD_BITS 4
`define XP_SRC_BITS 3
// Enable bit is the last bit of a field to arrive
`define XP_EN_POS 0
// Source bit j sits at XP_SRC0_POS - j inside a field
`define XP_SRC0_POS 3

// ****************************************************************
// Timing
// ****************************************************************
`define XP_CLK_NS 10
`define XP_SCLK_HALF_NS 80
`define XP_SCLK_HALF_CYC ((`XP_SCLK_HALF_NS + `XP_CLK_NS - 1) / `XP_CLK_NS)
`define XP_UPD_LOW_NS 80
`define XP_UPD_LOW_CYC ((`XP_UPD_LOW_NS + `XP_CLK_NS - 1) / `XP_CLK_NS)

`endif
